// ==== pus_sequencer.v ====
// Notes on behaviour
// - power-up enters normal-request: main on, secondary off, transceiver transmit-receive.
// - no watchdog timing write within 350ms: pulse reset, back to normal-request.
// - watchdog-fault output held low while waiting for first watchdog write.
// - first watchdog write: normal state, secondary on, fault released, reset high.
// - missed watchdog refresh in normal state: reset, then back to normal-request.
// - main under-voltage with stop choice: reset state, reset output asserted.
// - stop-choice under-voltage reset drives interrupt output low.
// - stop-choice under-voltage removed: restart in normal-request.
// - sleep choice, battery-fail cleared, under-voltage: stay in reset 100ms.
// - sleep-choice under-voltage reset holds reset and interrupt low.
// - after 100ms sleep-choice reset: sleep state, both regulators off.
// - both under-voltage resets keep watchdog-fault output high.
`timescale 1ns/1ns
`include "pus_regs.vh"

module pus_sequencer #(
    parameter CLK_HZ = `PUS_CLK_HZ,
    parameter NREQ_TIMEOUT_CYC = `PUS_NREQ_TIMEOUT_MS * `PUS_CYC_PER_MS,
    parameter UV_SLEEP_CYC = `PUS_UV_SLEEP_RESET_MS * `PUS_CYC_PER_MS,
    parameter CNT_W = `PUS_CNT_W
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // host-side events
    input wire watchdog_timing_reg_wr,
    input wire watchdog_refresh_missed,
    // supply and configuration status
    input wire main_uv,
    input wire low_power_choice,
    input wire battery_fail_flag,
    // pins toward host
    output reg reset_out_n_r,
    output reg int_out_n_r,
    output reg watchdog_fault_out_n_r,
    // power and transceiver control
    output reg main_regulator_en_r,
    output reg secondary_regulator_en_r,
    output reg transmit_receive_mode_r,
    // state view
    output reg [5:0] state_r
);

////////////////////////////////////////////////////////////////////////////////

localparam [5:0] ST_NREQ = 6'h01;
localparam [5:0] ST_NORMAL = 6'h02;
localparam [5:0] ST_WD_RESET = 6'h04;
localparam [5:0] ST_UV_STOP = 6'h08;
localparam [5:0] ST_UV_SLEEP = 6'h10;
localparam [5:0] ST_SLEEP = 6'h20;

localparam [CNT_W-1:0] NREQ_LIM = NREQ_TIMEOUT_CYC;
localparam [CNT_W-1:0] SLEEP_LIM = UV_SLEEP_CYC;

reg [5:0] state_nxt;
wire [CNT_W-1:0] limit_sel;
wire timer_expired;
wire state_change;

////////////////////////////////////////////////////////////////////////////////
// decode helpers

// under-voltage with sleep chosen and battery-fail cleared
function uv_sleep_hit;
    input uv;
    input choice;
    input fail;
    begin
        uv_sleep_hit = uv && (choice == `PUS_LP_SLEEP) && !fail;
    end
endfunction

// any other under-voltage falls back to the stop reaction
function uv_stop_hit;
    input uv;
    input choice;
    input fail;
    begin
        uv_stop_hit = uv && !((choice == `PUS_LP_SLEEP) && !fail);
    end
endfunction

// interval the timer counts toward in each state
function [CNT_W-1:0] limit_for;
    input [5:0] st;
    begin
        case (st)
            ST_NREQ: begin
                limit_for = NREQ_LIM;
            end
            ST_UV_SLEEP: begin
                limit_for = SLEEP_LIM;
            end
            ST_NORMAL: begin
                limit_for = NREQ_LIM;
            end
            ST_WD_RESET: begin
                limit_for = NREQ_LIM;
            end
            ST_UV_STOP: begin
                limit_for = NREQ_LIM;
            end
            ST_SLEEP: begin
                limit_for = NREQ_LIM;
            end
            default: begin
                limit_for = NREQ_LIM;
            end
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// interval timer

assign state_change = (state_nxt != state_r);

assign limit_sel = limit_for(state_r);

pus_interval_timer #(
    .CNT_W(CNT_W)
) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(state_change),
    .limit(limit_sel),
    .expired_r(timer_expired)
);

////////////////////////////////////////////////////////////////////////////////
// next state

always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_NREQ: begin
            if (uv_sleep_hit(main_uv, low_power_choice, battery_fail_flag)) begin
                state_nxt = ST_UV_SLEEP;
            end else if (uv_stop_hit(main_uv, low_power_choice, battery_fail_flag)) begin
                state_nxt = ST_UV_STOP;
            end else if (watchdog_timing_reg_wr) begin
                state_nxt = ST_NORMAL;
            end else if (timer_expired) begin
                state_nxt = ST_WD_RESET;
            end
        end
        ST_NORMAL: begin
            if (uv_sleep_hit(main_uv, low_power_choice, battery_fail_flag)) begin
                state_nxt = ST_UV_SLEEP;
            end else if (uv_stop_hit(main_uv, low_power_choice, battery_fail_flag)) begin
                state_nxt = ST_UV_STOP;
            end else if (watchdog_refresh_missed) begin
                state_nxt = ST_WD_RESET;
            end
        end
        ST_WD_RESET: begin
            state_nxt = ST_NREQ;
        end
        ST_UV_STOP: begin
            if (!main_uv) begin
                state_nxt = ST_NREQ;
            end
        end
        ST_UV_SLEEP: begin
            if (timer_expired) begin
                state_nxt = ST_SLEEP;
            end
        end
        ST_SLEEP: begin
            state_nxt = ST_SLEEP;
        end
        default: begin
            state_nxt = ST_NREQ;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// pin decode

reg reset_out_n_nxt;
reg int_out_n_nxt;
reg watchdog_fault_out_n_nxt;
reg main_regulator_en_nxt;
reg secondary_regulator_en_nxt;
reg transmit_receive_mode_nxt;

// pins follow the state being entered so they change with state_r
always @* begin
    reset_out_n_nxt = `PUS_PIN_HIGH;
    int_out_n_nxt = `PUS_PIN_HIGH;
    watchdog_fault_out_n_nxt = `PUS_PIN_HIGH;
    case (state_nxt)
        ST_NREQ: begin
            reset_out_n_nxt = `PUS_PIN_HIGH;
            int_out_n_nxt = `PUS_PIN_HIGH;
            watchdog_fault_out_n_nxt = `PUS_PIN_LOW;
        end

        ST_NORMAL: begin
            reset_out_n_nxt = `PUS_PIN_HIGH;
            int_out_n_nxt = `PUS_PIN_HIGH;
            watchdog_fault_out_n_nxt = `PUS_PIN_HIGH;
        end

        ST_WD_RESET: begin
            reset_out_n_nxt = `PUS_PIN_LOW;
            int_out_n_nxt = `PUS_PIN_HIGH;
            watchdog_fault_out_n_nxt = `PUS_PIN_LOW;
        end

        ST_UV_STOP: begin
            reset_out_n_nxt = `PUS_PIN_LOW;
            int_out_n_nxt = `PUS_PIN_LOW;
            watchdog_fault_out_n_nxt = `PUS_PIN_HIGH;
        end

        ST_UV_SLEEP: begin
            reset_out_n_nxt = `PUS_PIN_LOW;
            int_out_n_nxt = `PUS_PIN_LOW;
            watchdog_fault_out_n_nxt = `PUS_PIN_HIGH;
        end

        ST_SLEEP: begin
            reset_out_n_nxt = `PUS_PIN_HIGH;
            int_out_n_nxt = `PUS_PIN_HIGH;
            watchdog_fault_out_n_nxt = `PUS_PIN_HIGH;
        end

        default: begin
            reset_out_n_nxt = `PUS_PIN_HIGH;
            int_out_n_nxt = `PUS_PIN_HIGH;
            watchdog_fault_out_n_nxt = `PUS_PIN_LOW;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// power decode

always @* begin
    main_regulator_en_nxt = 1'b1;
    secondary_regulator_en_nxt = 1'b0;
    transmit_receive_mode_nxt = 1'b1;
    case (state_nxt)
        ST_NREQ: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b1;
        end

        ST_NORMAL: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b1;
            transmit_receive_mode_nxt = 1'b1;
        end

        ST_WD_RESET: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b1;
        end

        ST_UV_STOP: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b1;
        end

        ST_UV_SLEEP: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b1;
        end

        ST_SLEEP: begin
            main_regulator_en_nxt = 1'b0;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b0;
        end

        default: begin
            main_regulator_en_nxt = 1'b1;
            secondary_regulator_en_nxt = 1'b0;
            transmit_receive_mode_nxt = 1'b1;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// state and pin registers

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_NREQ;
        reset_out_n_r <= `PUS_PIN_HIGH;
        int_out_n_r <= `PUS_PIN_HIGH;
        watchdog_fault_out_n_r <= `PUS_PIN_LOW;
        main_regulator_en_r <= 1'b1;
        secondary_regulator_en_r <= 1'b0;
        transmit_receive_mode_r <= 1'b1;
    end else begin
        state_r <= state_nxt;
        reset_out_n_r <= reset_out_n_nxt;
        int_out_n_r <= int_out_n_nxt;
        watchdog_fault_out_n_r <= watchdog_fault_out_n_nxt;
        main_regulator_en_r <= main_regulator_en_nxt;
        secondary_regulator_en_r <= secondary_regulator_en_nxt;
        transmit_receive_mode_r <= transmit_receive_mode_nxt;
    end
end

endmodule

// ==== pus_regs.vh ====
`ifndef PUS_REGS_VH
`define PUS_REGS_VH

// time base
`define PUS_CLK_HZ 10000000
`define PUS_NREQ_TIMEOUT_MS 350
`define PUS_UV_SLEEP_RESET_MS 100
`define PUS_CYC_PER_MS (`PUS_CLK_HZ / 1000)

// pin levels
`define PUS_PIN_LOW 1'b0
`define PUS_PIN_HIGH 1'b1

// low-power choice encoding
`define PUS_LP_STOP 1'b0
`define PUS_LP_SLEEP 1'b1

// counter widths
`define PUS_CNT_W 32

`endif

// ==== pus_interval_timer.v ====
`timescale 1ns/1ns
`include "pus_regs.vh"

module pus_interval_timer #(
    parameter CNT_W = `PUS_CNT_W
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // control
    input wire clear,
    input wire [CNT_W-1:0] limit,
    // status
    output reg expired_r
);

reg [CNT_W-1:0] count_r;
wire [CNT_W-1:0] count_nxt;

assign count_nxt = clear ? {CNT_W{1'b0}} :
                   ((count_r == limit) ? count_r : count_r + {{(CNT_W-1){1'b0}}, 1'b1});

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        count_r <= {CNT_W{1'b0}};
        expired_r <= 1'b0;
    end else begin
        count_r <= count_nxt;
        expired_r <= (!clear) && (count_nxt == limit);
    end
end

endmodule

// ==== pus_chk.sv ====
`timescale 1ns/1ns
module pus_chk (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // events and status
    input logic watchdog_timing_reg_wr,
    input logic watchdog_refresh_missed,
    input logic main_uv,
    input logic low_power_choice,
    input logic battery_fail_flag,
    // pins and state
    input logic reset_out_n_r,
    input logic int_out_n_r,
    input logic watchdog_fault_out_n_r,
    input logic main_regulator_en_r,
    input logic secondary_regulator_en_r,
    input logic transmit_receive_mode_r,
    input logic [5:0] state_r
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_nreq_pin_levels: assert property (state_r == 6'h01 |-> main_regulator_en_r &&
        !secondary_regulator_en_r && transmit_receive_mode_r && !watchdog_fault_out_n_r)
        else $error("nreq pins");
    a_first_wd_write: assert property (state_r == 6'h01 && watchdog_timing_reg_wr &&
        !main_uv |=> state_r == 6'h02 && secondary_regulator_en_r && watchdog_fault_out_n_r
        && reset_out_n_r) else $error("first write");
    a_missed_refresh: assert property (state_r == 6'h02 && watchdog_refresh_missed &&
        !main_uv |=> state_r == 6'h04 && !reset_out_n_r ##1 state_r == 6'h01)
        else $error("missed refresh");
    a_uv_stop_entry: assert property (state_r == 6'h01 && main_uv &&
        !low_power_choice |=> state_r == 6'h08) else $error("uv stop");
    a_uv_stop_exit: assert property (state_r == 6'h08 && !main_uv |=>
        state_r == 6'h01) else $error("stop exit");
    a_uv_sleep_entry: assert property (state_r == 6'h01 && main_uv && low_power_choice &&
        !battery_fail_flag |=> state_r == 6'h10 [*8]) else $error("uv sleep");
    a_uv_pin_levels: assert property (state_r == 6'h08 || state_r == 6'h10 |->
        !reset_out_n_r && !int_out_n_r && watchdog_fault_out_n_r) else $error("uv pins");
    a_sleep_regs_off: assert property (state_r == 6'h20 |-> !main_regulator_en_r &&
        !secondary_regulator_en_r) else $error("sleep regs");
endmodule
bind pus_sequencer pus_chk u_chk (.*);

// ==== pus_host_model.sv ====
`timescale 1ns/1ns
module pus_host_model (
    input logic core_clk,
    input logic arm,
    input logic watchdog_fault_out_n_r,
    output logic wd_wr = 1'b0
);
    // one timing write while the fault pin asks for service
    always @(posedge core_clk) wd_wr <= arm && !watchdog_fault_out_n_r && !wd_wr;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
    logic core_clk = 0, rst_n = 0, arm = 0, missed = 0, uv = 0, choice = 0, bf = 0, wr;
    logic ro, io, wf, me, se, tx;
    logic [5:0] st;
    int fails = 0, checks = 0, n = 0;
    always #50 core_clk = ~core_clk;
    pus_sequencer #(.NREQ_TIMEOUT_CYC(40), .UV_SLEEP_CYC(20)) u_dut (.core_clk(core_clk),
        .rst_n(rst_n), .watchdog_timing_reg_wr(wr), .watchdog_refresh_missed(missed),
        .main_uv(uv), .low_power_choice(choice), .battery_fail_flag(bf),
        .reset_out_n_r(ro), .int_out_n_r(io), .watchdog_fault_out_n_r(wf),
        .main_regulator_en_r(me), .secondary_regulator_en_r(se),
        .transmit_receive_mode_r(tx), .state_r(st));
    pus_host_model u_host (.core_clk(core_clk), .arm(arm), .watchdog_fault_out_n_r(wf),
        .wd_wr(wr));
    task chk(string what, logic [5:0] exp, logic [5:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task step(int k);
        repeat (k) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task wait_st(logic [5:0] s);
        n = 0;
        while (st !== s && n < 60) begin
            @(negedge core_clk);
            n++;
        end
    endtask
    task t_power_up_timeout;
        chk("state", 6'h01, st);
        chk("pins", 6'h35, {ro, io, wf, me, se, tx});
        wait_st(6'h04);
        chk("timeout", 1, n >= 38 && n <= 44);
        chk("reset", 0, ro);
        step(0);
        chk("state", 6'h01, st);
        $display("power_up_timeout done");
    endtask
    task t_first_write;
        @(posedge core_clk) arm <= 1;
        wait_st(6'h02);
        @(posedge core_clk) arm <= 0;
        step(0);
        chk("state", 6'h02, st);
        chk("pins", 6'h0F, {ro, wf, me, se});
        @(posedge core_clk) missed <= 1;
        @(posedge core_clk) missed <= 0;
        step(0);
        chk("state", 6'h04, st);
        chk("reset", 0, ro);
        step(0);
        chk("state", 6'h01, st);
        $display("first_write done");
    endtask
    task t_uv_stop;
        @(posedge core_clk) uv <= 1;
        step(4);
        chk("state", 6'h08, st);
        chk("pins", 6'h01, {ro, io, wf});
        @(posedge core_clk) uv <= 0;
        step(1);
        chk("state", 6'h01, st);
        @(posedge core_clk) begin
            uv <= 1;
            choice <= 1;
            bf <= 1;
        end
        step(1);
        chk("state", 6'h08, st);
        @(posedge core_clk) begin
            uv <= 0;
            choice <= 0;
            bf <= 0;
        end
        step(1);
        chk("state", 6'h01, st);
        $display("uv_stop done");
    endtask
    task t_uv_sleep;
        @(posedge core_clk) begin
            uv <= 1;
            choice <= 1;
        end
        step(1);
        chk("state", 6'h10, st);
        chk("pins", 6'h01, {ro, io, wf});
        @(posedge core_clk) uv <= 0;
        wait_st(6'h20);
        chk("hold", 1, n >= 18 && n <= 24);
        chk("regs", 6'h00, {me, se});
        $display("uv_sleep done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        step(1);
        t_power_up_timeout;
        t_first_write;
        t_uv_stop;
        t_uv_sleep;
        give_verdict;
    end
    initial begin
        #100000;
        fails++;
        give_verdict;
    end
endmodule
